// *** hdl/frame_shift_pkg.sv ***
// Shared types and constants of the accumulator-load, frame and shift executor.
// Assumes a single core clock and a core that decodes operands before issue.
package frame_shift_pkg;

  //////////////////////////////////////////////////////////////////////////////
  // Register bus map
  localparam logic [7:0]  ADDR_CTRL     = 8'h00;
  localparam logic [7:0]  ADDR_STATUS   = 8'h04;
  localparam logic [7:0]  ADDR_EVENT    = 8'h08;
  localparam logic [7:0]  ADDR_MASK     = 8'h0C;
  localparam logic [7:0]  ADDR_FP       = 8'h10;
  localparam logic [7:0]  ADDR_SP       = 8'h14;
  localparam logic [7:0]  ADDR_ACCUMULATOR_A_LO  = 8'h18;
  localparam logic [7:0]  ADDR_ACCUMULATOR_A_HI  = 8'h1C;
  localparam logic [7:0]  ADDR_ACCUMULATOR_B_LO  = 8'h20;
  localparam logic [7:0]  ADDR_ACCUMULATOR_B_HI  = 8'h24;

  // Control fields
  localparam int CTRL_LATER_BIT  = 0;
  localparam int CTRL_CLIP_A_BIT = 1;
  localparam int CTRL_CLIP_B_BIT = 2;
  localparam logic [2:0] CTRL_RESET = 3'h0;

  // Status word fields
  localparam int ST_CARRY   = 0;
  localparam int ST_ZERO    = 1;
  localparam int ST_NEG     = 2;
  localparam int ST_FRAME   = 3;
  localparam int ST_OVF_A   = 4;
  localparam int ST_OVF_B   = 5;
  localparam int ST_OVF_ANY = 6;
  localparam int ST_CLIP_A  = 7;
  localparam int ST_CLIP_B  = 8;
  localparam int ST_CLIP_ANY = 9;
  localparam int ST_WIDTH   = 10;
  localparam logic [9:0] STATUS_RESET = 10'h000;

  // Event fields, read-to-clear
  localparam int EV_OVF   = 0;
  localparam int EV_CLIP  = 1;
  localparam int EV_FRAME = 2;
  localparam int EV_DONE  = 3;
  localparam int EV_WIDTH = 4;
  localparam logic [3:0] EVENT_RESET = 4'h0;
  localparam logic [3:0] MASK_RESET  = 4'h0;

  // Datapath constants
  localparam logic [15:0] WORD_STEP       = 16'h0002;
  localparam logic [15:0] SP_RESET        = 16'h0800;
  localparam logic [15:0] FP_RESET        = 16'h0800;
  localparam logic [3:0]  DEFAULT_REG_IDX = 4'h0;
  localparam logic [39:0] ACC_POS_MAX     = 40'h007FFFFFFF;
  localparam logic [39:0] ACC_NEG_MAX     = 40'hFF80000000;
  localparam logic [39:0] ACC_RESET       = 40'h0000000000;

  typedef enum logic [1:0] {
    OP_NONE        = 2'b00,
    OP_ACC_LOAD    = 2'b01,
    OP_FRAME_ALLOC = 2'b10,
    OP_LSR         = 2'b11
  } exec_op_t;

  typedef enum logic [1:0] {
    AM_DIRECT   = 2'b00,
    AM_POST_INC = 2'b01,
    AM_PRE_DEC  = 2'b10,
    AM_INDIRECT = 2'b11
  } addr_mode_t;

  typedef struct packed {
    logic              valid;
    exec_op_t          op;
    logic              acc_b;
    logic signed [3:0] shamt;
    logic              byte_mode;
    logic              file_form;
    logic              to_default;
    addr_mode_t        src_mode;
    logic [3:0]        src_idx;
    logic [15:0]       src_ptr;
    logic [15:0]       operand;
    logic [3:0]        dest_idx;
    logic [15:0]       dest_old;
    logic [12:0]       file_addr;
    logic [13:0]       frame_lit;
  } exec_req_t;

  typedef struct packed {
    logic        reg_wr;
    logic [3:0]  reg_idx;
    logic [15:0] reg_data;
    logic        mem_wr;
    logic        mem_byte;
    logic [15:0] mem_addr;
    logic [15:0] mem_data;
    logic        ptr_wr;
    logic [3:0]  ptr_idx;
    logic [15:0] ptr_data;
  } exec_res_t;

  localparam exec_res_t RES_RESET = '0;

endpackage : frame_shift_pkg

// *** hdl/acc_load_shift.sv ***
// Combinational shifter for the accumulator load: places a fraction word in
// bits 31:16 and applies a signed shift. Assumes the caller clips on spill.
`timescale 1ns/1ps
module acc_load_shift
  import frame_shift_pkg::*;
(
  input  wire logic [15:0]       src_in,
  input  wire logic signed [3:0] shamt_in,
  output logic      [39:0]       value_out,
  output logic                   spill_out
);

  wire logic signed [39:0] base    = {{8{src_in[15]}}, src_in, 16'h0000};
  wire logic        [3:0]  lsh     = 4'(~shamt_in + 4'sh1);
  wire logic signed [39:0] shl_val = base <<< lsh;
  wire logic signed [39:0] shr_val = base >>> shamt_in[2:0];

  assign value_out = shamt_in[3] ? shl_val : shr_val;
  // Bits above the sign of bit 31 must all agree, else the upper byte is used
  assign spill_out = !((&value_out[39:31]) || !(|value_out[39:31]));

endmodule : acc_load_shift

// *** hdl/right_shift_one.sv ***
// Logical right shift by one in byte or word size with carry, negative, zero.
// Assumes the caller supplies the upper byte to keep in byte mode.
`timescale 1ns/1ps
module right_shift_one
  import frame_shift_pkg::*;
(
  input  wire logic [15:0] operand_in,
  input  wire logic        byte_mode_in,
  input  wire logic [7:0]  keep_upper_in,
  output logic      [15:0] result_out,
  output logic             carry_out,
  output logic             neg_out,
  output logic             zero_out
);

  assign result_out = byte_mode_in ? {keep_upper_in, 1'b0, operand_in[7:1]}
                                   : {1'b0, operand_in[15:1]};
  assign carry_out  = operand_in[0];
  assign neg_out    = byte_mode_in ? result_out[7] : result_out[15];
  assign zero_out   = byte_mode_in ? (result_out[7:0] == 8'h00)
                                   : (result_out == 16'h0000);

endmodule : right_shift_one

// *** hdl/frame_shift_exec.sv ***
// Executor for accumulator load, stack frame allocation and right shift by one.
// Assumes the core decodes addressing, supplies operands and applies results.
`timescale 1ns/1ps
module frame_shift_exec
  import frame_shift_pkg::*;
(
  input  wire logic        clk_sys_in,
  input  wire logic        srst_in,
  input  wire exec_req_t   req_in,
  output exec_res_t        res_out,
  output logic             done_out,
  output logic [15:0]      fp_out,
  output logic [15:0]      sp_out,
  output logic [ST_WIDTH-1:0] status_out,
  input  wire logic [7:0]  bus_addr_in,
  input  wire logic [31:0] bus_wdata_in,
  input  wire logic        bus_wr_in,
  input  wire logic        bus_rd_in,
  output logic [31:0]      bus_rdata_out,
  output logic             irq_out
);

  function automatic logic [15:0] ptr_step(input addr_mode_t m, input logic [15:0] p);
    case (m)
      AM_POST_INC: ptr_step = p + WORD_STEP;
      AM_PRE_DEC:  ptr_step = p - WORD_STEP;
      default:     ptr_step = p;
    endcase
  endfunction : ptr_step

  function automatic logic [31:0] pad_word(input logic [15:0] v);
    pad_word = {16'h0000, v};
  endfunction : pad_word

  //////////////////////////////////////////////////////////////////////////////
  // State
  logic [2:0]          ctrl_q;
  logic [ST_WIDTH-1:0] status_q, status_d;
  logic [EV_WIDTH-1:0] event_q, event_d, mask_q;
  logic [15:0]         fp_q, fp_d, sp_q, sp_d;
  logic [39:0]         acc_a_q, acc_a_d, acc_b_q, acc_b_d;
  exec_res_t           res_q, res_d;
  logic                done_q;
  logic [31:0]         rdata_q;

  //////////////////////////////////////////////////////////////////////////////
  // Operation decode
  wire logic go_load  = req_in.valid && (req_in.op == OP_ACC_LOAD);
  wire logic go_frame = req_in.valid && (req_in.op == OP_FRAME_ALLOC);
  wire logic go_lsr   = req_in.valid && (req_in.op == OP_LSR);
  wire logic later    = ctrl_q[CTRL_LATER_BIT];

  //////////////////////////////////////////////////////////////////////////////
  // Accumulator load path
  logic [39:0] load_val;
  logic        load_spill;

  acc_load_shift u_acc_shift (
    .src_in    (req_in.operand),
    .shamt_in  (req_in.shamt),
    .value_out (load_val),
    .spill_out (load_spill)
  );

  wire logic clip_en   = req_in.acc_b ? ctrl_q[CTRL_CLIP_B_BIT] : ctrl_q[CTRL_CLIP_A_BIT];
  wire logic load_ovf  = go_load && load_spill && !clip_en;
  wire logic load_clip = go_load && load_spill && clip_en;
  wire logic [39:0] acc_new = load_clip ? (load_val[39] ? ACC_NEG_MAX : ACC_POS_MAX)
                                        : load_val;

  //////////////////////////////////////////////////////////////////////////////
  // Right shift path
  logic [15:0] lsr_val;
  logic        lsr_c, lsr_n, lsr_z;

  right_shift_one u_rshift (
    .operand_in    (req_in.operand),
    .byte_mode_in  (req_in.byte_mode),
    .keep_upper_in (req_in.dest_old[15:8]),
    .result_out    (lsr_val),
    .carry_out     (lsr_c),
    .neg_out       (lsr_n),
    .zero_out      (lsr_z)
  );

  wire logic lsr_to_mem = req_in.file_form && !req_in.to_default;
  wire logic [3:0] lsr_idx = req_in.file_form ? DEFAULT_REG_IDX : req_in.dest_idx;

  //////////////////////////////////////////////////////////////////////////////
  // Frame path
  wire logic [15:0] sp_pushed = sp_q + WORD_STEP;
  wire logic [15:0] sp_frame  = sp_pushed + {2'b00, req_in.frame_lit};

  //////////////////////////////////////////////////////////////////////////////
  // Bus decode
  wire logic wr_ctrl   = bus_wr_in && (bus_addr_in == ADDR_CTRL);
  wire logic wr_status = bus_wr_in && (bus_addr_in == ADDR_STATUS);
  wire logic wr_mask   = bus_wr_in && (bus_addr_in == ADDR_MASK);
  wire logic wr_fp     = bus_wr_in && (bus_addr_in == ADDR_FP);
  wire logic wr_sp     = bus_wr_in && (bus_addr_in == ADDR_SP);
  wire logic rd_event  = bus_rd_in && (bus_addr_in == ADDR_EVENT);

  logic [31:0] rdata_d;
  always_comb
  begin
    case (bus_addr_in)
      ADDR_CTRL:    rdata_d = {29'h0, ctrl_q};
      ADDR_STATUS:  rdata_d = {22'h0, status_q};
      ADDR_EVENT:   rdata_d = {28'h0, event_q};
      ADDR_MASK:    rdata_d = {28'h0, mask_q};
      ADDR_FP:      rdata_d = pad_word(fp_q);
      ADDR_SP:      rdata_d = pad_word(sp_q);
      ADDR_ACCUMULATOR_A_LO: rdata_d = acc_a_q[31:0];
      ADDR_ACCUMULATOR_A_HI: rdata_d = {24'h0, acc_a_q[39:32]};
      ADDR_ACCUMULATOR_B_LO: rdata_d = acc_b_q[31:0];
      ADDR_ACCUMULATOR_B_HI: rdata_d = {24'h0, acc_b_q[39:32]};
      default:      rdata_d = 32'h0000_0000;
    endcase
    if (!bus_rd_in)
      rdata_d = 32'h0000_0000;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Next state of the architectural registers
  always_comb
  begin
    res_d    = RES_RESET;
    status_d = wr_status ? bus_wdata_in[ST_WIDTH-1:0] : status_q;
    fp_d     = wr_fp ? bus_wdata_in[15:0] : fp_q;
    sp_d     = wr_sp ? bus_wdata_in[15:0] : sp_q;
    acc_a_d  = acc_a_q;
    acc_b_d  = acc_b_q;
    case (req_in.op)
      OP_ACC_LOAD:
      begin
        if (go_load)
        begin
          if (req_in.acc_b)
          begin
            acc_b_d              = acc_new;
            status_d[ST_OVF_B]   = load_ovf;
            status_d[ST_CLIP_B]  = status_d[ST_CLIP_B] | load_clip;
          end
          else
          begin
            acc_a_d              = acc_new;
            status_d[ST_OVF_A]   = load_ovf;
            status_d[ST_CLIP_A]  = status_d[ST_CLIP_A] | load_clip;
          end
          res_d.ptr_wr   = (req_in.src_mode == AM_POST_INC) || (req_in.src_mode == AM_PRE_DEC);
          res_d.ptr_idx  = req_in.src_idx;
          res_d.ptr_data = ptr_step(req_in.src_mode, req_in.src_ptr);
        end
      end
      OP_FRAME_ALLOC:
      begin
        if (go_frame)
        begin
          res_d.mem_wr   = 1'b1;
          res_d.mem_addr = sp_q;
          res_d.mem_data = fp_q;
          fp_d           = sp_pushed;
          sp_d           = sp_frame;
          if (later)
            status_d[ST_FRAME] = 1'b1;
        end
      end
      OP_LSR:
      begin
        if (go_lsr)
        begin
          res_d.mem_wr   = lsr_to_mem;
          res_d.mem_byte = req_in.byte_mode;
          res_d.mem_addr = {3'b000, req_in.file_addr};
          res_d.mem_data = lsr_val;
          res_d.reg_wr   = !lsr_to_mem;
          res_d.reg_idx  = lsr_idx;
          res_d.reg_data = lsr_val;
          res_d.ptr_wr   = !req_in.file_form &&
                           ((req_in.src_mode == AM_POST_INC) || (req_in.src_mode == AM_PRE_DEC));
          res_d.ptr_idx  = req_in.src_idx;
          res_d.ptr_data = ptr_step(req_in.src_mode, req_in.src_ptr);
          status_d[ST_CARRY] = lsr_c;
          status_d[ST_NEG]   = lsr_n;
          status_d[ST_ZERO]  = lsr_z;
        end
      end
      default:
      begin
        res_d = RES_RESET;
      end
    endcase
    status_d[ST_OVF_ANY]  = status_d[ST_OVF_A] | status_d[ST_OVF_B];
    status_d[ST_CLIP_ANY] = status_d[ST_CLIP_A] | status_d[ST_CLIP_B];
  end

  // Events set wins over the read that clears them
  wire logic [EV_WIDTH-1:0] ev_new = {req_in.valid && (req_in.op != OP_NONE),
                                      go_frame, load_clip, load_ovf};
  assign event_d = (rd_event ? EVENT_RESET : event_q) | ev_new;

  //////////////////////////////////////////////////////////////////////////////
  // Registers
  always_ff @(posedge clk_sys_in)
  begin
    if (srst_in)
    begin
      ctrl_q   <= CTRL_RESET;
      status_q <= STATUS_RESET;
      event_q  <= EVENT_RESET;
      mask_q   <= MASK_RESET;
      fp_q     <= FP_RESET;
      sp_q     <= SP_RESET;
      acc_a_q  <= ACC_RESET;
      acc_b_q  <= ACC_RESET;
      res_q    <= RES_RESET;
      done_q   <= 1'b0;
      rdata_q  <= 32'h0000_0000;
    end
    else
    begin
      ctrl_q   <= wr_ctrl ? bus_wdata_in[2:0] : ctrl_q;
      status_q <= status_d;
      event_q  <= event_d;
      mask_q   <= wr_mask ? bus_wdata_in[EV_WIDTH-1:0] : mask_q;
      fp_q     <= fp_d;
      sp_q     <= sp_d;
      acc_a_q  <= acc_a_d;
      acc_b_q  <= acc_b_d;
      res_q    <= res_d;
      done_q   <= req_in.valid && (req_in.op != OP_NONE);
      rdata_q  <= rdata_d;
    end
  end

  assign res_out       = res_q;
  assign done_out      = done_q;
  assign fp_out        = fp_q;
  assign sp_out        = sp_q;
  assign status_out    = status_q;
  assign bus_rdata_out = rdata_q;
  assign irq_out       = |(event_q & mask_q);

  //////////////////////////////////////////////////////////////////////////////
  // Checks
  property p_done_one_cycle;
    @(posedge clk_sys_in) disable iff (srst_in)
    (req_in.valid && req_in.op != OP_NONE) |=> done_out;
  endproperty
  a_done_one_cycle: assert property (p_done_one_cycle) else $error("op not done in one cycle");

  property p_load_unshifted;
    @(posedge clk_sys_in) disable iff (srst_in)
    (go_load && !req_in.acc_b && req_in.shamt == 4'sh0)
      |=> (acc_a_q[31:0] == {$past(req_in.operand), 16'h0000});
  endproperty
  a_load_unshifted: assert property (p_load_unshifted) else $error("load placement wrong");

  property p_load_right;
    @(posedge clk_sys_in) disable iff (srst_in)
    (go_load && req_in.acc_b && req_in.shamt == 4'sh7)
      |=> (acc_b_q == {{15{$past(req_in.operand[15])}}, $past(req_in.operand), 9'h000});
  endproperty
  a_load_right: assert property (p_load_right) else $error("arith right shift wrong");

  property p_ptr_update;
    @(posedge clk_sys_in) disable iff (srst_in)
    (go_load && req_in.src_mode == AM_PRE_DEC)
      |=> (res_out.ptr_wr && res_out.ptr_data == $past(req_in.src_ptr) - WORD_STEP
           && !res_out.mem_wr);
  endproperty
  a_ptr_update: assert property (p_ptr_update) else $error("pointer update wrong");

  property p_overflow;
    @(posedge clk_sys_in) disable iff (srst_in)
    (go_load && load_spill && !clip_en)
      |=> (status_q[ST_OVF_ANY]
           && ($past(req_in.acc_b) ? status_q[ST_OVF_B] : status_q[ST_OVF_A]));
  endproperty
  a_overflow: assert property (p_overflow) else $error("overflow flag not set");

  property p_frame_ptrs;
    @(posedge clk_sys_in) disable iff (srst_in)
    go_frame |=> (fp_q == $past(sp_q) + WORD_STEP)
              && (sp_q == $past(sp_q) + WORD_STEP + {2'b00, $past(req_in.frame_lit)})
              && res_out.mem_wr && (res_out.mem_data == $past(fp_q));
  endproperty
  a_frame_ptrs: assert property (p_frame_ptrs) else $error("frame pointers wrong");

  property p_frame_active;
    @(posedge clk_sys_in) disable iff (srst_in)
    (go_frame && later) |=> status_q[ST_FRAME];
  endproperty
  a_frame_active: assert property (p_frame_active) else $error("frame flag not set");

  property p_frame_flags;
    @(posedge clk_sys_in) disable iff (srst_in)
    (go_frame && !bus_wr_in)
      |=> (status_q[ST_NEG:ST_CARRY] == $past(status_q[ST_NEG:ST_CARRY]));
  endproperty
  a_frame_flags: assert property (p_frame_flags) else $error("frame changed flags");

  property p_word_shift;
    @(posedge clk_sys_in) disable iff (srst_in)
    (go_lsr && !req_in.byte_mode && !lsr_to_mem)
      |=> (res_out.reg_data == {1'b0, $past(req_in.operand[15:1])})
          && (status_q[ST_CARRY] == $past(req_in.operand[0]));
  endproperty
  a_word_shift: assert property (p_word_shift) else $error("word shift wrong");

  property p_byte_keep;
    @(posedge clk_sys_in) disable iff (srst_in)
    (go_lsr && req_in.byte_mode && !req_in.file_form)
      |=> (res_out.reg_data[15:8] == $past(req_in.dest_old[15:8]));
  endproperty
  a_byte_keep: assert property (p_byte_keep) else $error("upper byte changed");

  property p_default_dest;
    @(posedge clk_sys_in) disable iff (srst_in)
    (go_lsr && req_in.file_form && req_in.to_default)
      |=> (!res_out.mem_wr && res_out.reg_wr && res_out.reg_idx == DEFAULT_REG_IDX);
  endproperty
  a_default_dest: assert property (p_default_dest) else $error("default dest wrong");

  property p_shift_nz;
    @(posedge clk_sys_in) disable iff (srst_in)
    go_lsr |=> !status_q[ST_NEG]
               && (status_q[ST_ZERO] == ($past(req_in.byte_mode) ?
                   ($past(req_in.operand[7:1]) == 7'h00) : ($past(req_in.operand[15:1]) == 15'h0)));
  endproperty
  a_shift_nz: assert property (p_shift_nz) else $error("shift N or Z wrong");

endmodule : frame_shift_exec

// *** test/core_side_model.sv ***
// Core side model: register file and data memory that take executor results.
// Assumes results arrive as one-cycle pulses on the core clock.
`timescale 1ns/1ps
module core_side_model
  import frame_shift_pkg::*;
(
  input  wire logic      clk_sys_in,
  input  wire logic      srst_in,
  input  wire exec_res_t res_in
);
  logic [15:0] mem_q [0:255];
  logic [15:0] reg_q [0:15];

  //////////////////////////////////////////////////////////////////////////
  // Storage update; byte writes touch the low byte only
  always @(posedge clk_sys_in)
  begin
    if (srst_in)
    begin
      for (int i = 0; i < 256; i++)
        mem_q[i] <= 16'(i * 16'h9E37);
    end
    else
    begin
      if (res_in.mem_wr && res_in.mem_byte)
        mem_q[res_in.mem_addr[7:0]][7:0] <= res_in.mem_data[7:0];
      else if (res_in.mem_wr)
        mem_q[res_in.mem_addr[7:0]] <= res_in.mem_data;
      if (res_in.reg_wr)
        reg_q[res_in.reg_idx] <= res_in.reg_data;
      if (res_in.ptr_wr)
        reg_q[res_in.ptr_idx] <= res_in.ptr_data;
    end
  end
endmodule : core_side_model

// *** test/tb_top.sv ***
// Bench for the executor: drivers queue expectations, a monitor compares.
// Assumes fixed one-cycle answers on both ports.
`timescale 1ns/1ps
module tb_top;
  import frame_shift_pkg::*;
  typedef struct packed {exec_res_t r; logic [15:0] f; logic [15:0] s; logic [9:0] t;} exp_t;
  typedef struct packed {logic [31:0] v; logic [31:0] m;} rdx_t;
  logic                clk_sys_in = 1'b0;
  logic                srst_in    = 1'b1;
  exec_req_t           req_q      = '0;
  logic [7:0]          addr_q     = 8'h00;
  logic [31:0]         wdata_q    = 32'h0;
  logic                wr_q       = 1'b0;
  logic                rd_q       = 1'b0;
  logic                rd_seen_q  = 1'b0;
  exec_res_t           res_out;
  logic                done_out;
  logic [15:0]         fp_out;
  logic [15:0]         sp_out;
  logic [ST_WIDTH-1:0] status_out;
  logic [31:0]         bus_rdata_out;
  logic                irq_out;
  exp_t                eq[$];
  rdx_t                rq[$];
  logic [39:0]         acc_m [2] = '{40'h0, 40'h0};
  logic [9:0]          st_m   = 10'h000;
  logic [3:0]          ev_m   = 4'h0;
  logic [2:0]          ctrl_m = 3'h0;
  logic [15:0]         fp_m   = FP_RESET;
  logic [15:0]         sp_m   = SP_RESET;
  int                  n_mismatch = 0;
  int                  compares   = 0;

  frame_shift_exec dut_u (.clk_sys_in(clk_sys_in), .srst_in(srst_in), .req_in(req_q),
    .res_out(res_out), .done_out(done_out), .fp_out(fp_out), .sp_out(sp_out),
    .status_out(status_out), .bus_addr_in(addr_q), .bus_wdata_in(wdata_q),
    .bus_wr_in(wr_q), .bus_rd_in(rd_q), .bus_rdata_out(bus_rdata_out), .irq_out(irq_out));
  core_side_model part_u (.clk_sys_in(clk_sys_in), .srst_in(srst_in), .res_in(res_out));

  always #50 clk_sys_in = ~clk_sys_in;

  //////////////////////////////////////////////////////////////////////////
  // Monitor
  task automatic err(string s);
    $display("Error at %0t: %s", $time, s);
    n_mismatch++;
  endtask : err
  task automatic cmp_exec(exp_t e);
    compares++;
    if ({res_out, fp_out, sp_out, status_out} !== e) err("exec result differs");
  endtask : cmp_exec
  task automatic cmp_rd(rdx_t x);
    compares++;
    if ((bus_rdata_out & x.m) !== (x.v & x.m)) err("read data differs");
  endtask : cmp_rd
  task automatic cmp_irq(logic x);
    @(negedge clk_sys_in);
    compares++;
    if (irq_out !== x) err("interrupt level differs");
  endtask : cmp_irq
  always @(posedge clk_sys_in) rd_seen_q <= rd_q;
  always @(negedge clk_sys_in)
  begin
    if (done_out !== 1'b0)
    begin
      if (eq.size() == 0) err("unexpected done");
      else cmp_exec(eq.pop_front());
    end
    if (rd_seen_q) cmp_rd(rq.pop_front());
  end

  //////////////////////////////////////////////////////////////////////////
  // Drivers
  task automatic bus(logic w, logic [7:0] a, logic [31:0] d, logic [31:0] m);
    @(posedge clk_sys_in);
    req_q.valid <= 1'b0;
    wr_q <= w;
    rd_q <= !w;
    addr_q <= a;
    wdata_q <= d;
    if (!w) rq.push_back('{d, m});
  endtask : bus
  task automatic idle(int n);
    repeat (n)
    begin
      @(posedge clk_sys_in);
      req_q.valid <= 1'b0;
      wr_q <= 1'b0;
      rd_q <= 1'b0;
    end
  endtask : idle
  task automatic issue(exec_req_t r, exec_res_t s);
    ev_m[EV_DONE] = 1'b1;
    eq.push_back('{s, fp_m, sp_m, st_m});
    @(posedge clk_sys_in);
    req_q <= r;
    wr_q <= 1'b0;
    rd_q <= 1'b0;
  endtask : issue
  task automatic do_load(logic b, int k, addr_mode_t md, logic [15:0] s);
    exec_req_t r;
    exec_res_t e;
    logic [39:0] v;
    logic sp_l;
    r = '0;
    e = '0;
    r.valid = 1'b1;
    r.op = OP_ACC_LOAD;
    r.acc_b = b;
    r.shamt = 4'(k);
    r.src_mode = md;
    r.src_idx = 4'h4;
    r.src_ptr = 16'h2000;
    r.operand = s;
    v = {{8{s[15]}}, s, 16'h0000};
    if (k < 0) v = v << (-k);
    else v = $signed(v) >>> k;
    sp_l = (v[39:31] != 9'h000) && (v[39:31] != 9'h1FF);
    if (ctrl_m[1 + b] && sp_l) v = v[39] ? ACC_NEG_MAX : ACC_POS_MAX;
    if (ctrl_m[1 + b] && sp_l) st_m[ST_CLIP_A + b] = 1'b1;
    if (ctrl_m[1 + b] && sp_l) ev_m[EV_CLIP] = 1'b1;
    if (!ctrl_m[1 + b] && sp_l) ev_m[EV_OVF] = 1'b1;
    acc_m[b] = v;
    st_m[ST_OVF_A + b] = sp_l && !ctrl_m[1 + b];
    st_m[ST_OVF_ANY] = st_m[ST_OVF_A] | st_m[ST_OVF_B];
    st_m[ST_CLIP_ANY] = st_m[ST_CLIP_A] | st_m[ST_CLIP_B];
    e.ptr_wr = (md == AM_POST_INC) || (md == AM_PRE_DEC);
    e.ptr_idx = 4'h4;
    e.ptr_data = (md == AM_POST_INC) ? 16'h2002 : (md == AM_PRE_DEC) ? 16'h1FFE : 16'h2000;
    issue(r, e);
  endtask : do_load
  task automatic do_frame(logic [13:0] lit);
    exec_req_t r;
    exec_res_t e;
    r = '0;
    e = '0;
    r.valid = 1'b1;
    r.op = OP_FRAME_ALLOC;
    r.frame_lit = lit;
    e.mem_wr = 1'b1;
    e.mem_addr = sp_m;
    e.mem_data = fp_m;
    fp_m = sp_m + WORD_STEP;
    sp_m = fp_m + 16'(lit);
    ev_m[EV_FRAME] = 1'b1;
    if (ctrl_m[0]) st_m[ST_FRAME] = 1'b1;
    issue(r, e);
  endtask : do_frame
  task automatic do_lsr(logic by, logic fl, logic df, logic [15:0] v, logic [7:0] fa);
    exec_req_t r;
    exec_res_t e;
    logic [15:0] q;
    r = '0;
    e = '0;
    r.valid = 1'b1;
    r.op = OP_LSR;
    r.byte_mode = by;
    r.file_form = fl;
    r.to_default = df;
    r.file_addr = {5'h00, fa};
    if (fl) v = part_u.mem_q[fa];
    r.operand = v;
    r.dest_idx = 4'h5;
    r.dest_old = by ? v ^ 16'h5A00 : v;
    q = by ? {r.dest_old[15:8], 1'b0, v[7:1]} : {1'b0, v[15:1]};
    st_m[ST_CARRY] = v[0];
    st_m[ST_NEG] = 1'b0;
    st_m[ST_ZERO] = by ? (v[7:1] == 7'h00) : (v[15:1] == 15'h0000);
    e.mem_wr = fl && !df;
    e.mem_byte = by;
    e.mem_addr = {8'h00, fa};
    e.mem_data = q;
    e.reg_wr = !e.mem_wr;
    e.reg_idx = fl ? DEFAULT_REG_IDX : 4'h5;
    e.reg_data = q;
    issue(r, e);
    if (fl) idle(3);
  endtask : do_lsr

  //////////////////////////////////////////////////////////////////////////
  // Closing
  task automatic summarize();
    $display("compares=%0d n_mismatch=%0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : summarize

  initial
  begin
    void'($urandom(32'hA6D4));
    repeat (12) @(posedge clk_sys_in);
    srst_in <= 1'b0;
    for (int a = 0; a <= 'h30; a += 4)
      bus(1'b0, 8'(a), (a == 'h10 || a == 'h14) ? 32'h0800 : 32'h0, 32'hFFFFFFFF);
    do_load(1'b1, -3, AM_POST_INC, 16'h1221);
    do_load(1'b0, 7, AM_PRE_DEC, 16'h9108);
    for (int k = -8; k < 8; k++) do_load(1'(k), k, AM_DIRECT, 16'($urandom));
    do_frame(14'h0000);
    do_frame(14'h3FFE);
    bus(1'b1, ADDR_CTRL, 32'h7, 32'h0);
    ctrl_m = 3'h7;
    do_frame(14'(($urandom % 8191) * 2));
    do_load(1'b0, -8, AM_DIRECT, 16'h4000);
    do_load(1'b1, -8, AM_INDIRECT, 16'hC001);
    do_lsr(1'b1, 1'b1, 1'b0, 16'h0, 8'h01);
    for (int i = 0; i < 24; i++)
      do_lsr(1'($urandom), 1'($urandom), 1'($urandom), 16'($urandom), 8'($urandom));
    do_lsr(1'b0, 1'b0, 1'b0, 16'h0001, 8'h00);
    bus(1'b0, ADDR_EVENT, 32'(ev_m), 32'hF);
    ev_m = 4'h0;
    bus(1'b1, ADDR_MASK, 32'h8, 32'h0);
    idle(2);
    cmp_irq(1'b0);
    do_lsr(1'b0, 1'b0, 1'b0, 16'h8000, 8'h00);
    idle(3);
    cmp_irq(1'b1);
    bus(1'b1, ADDR_MASK, 32'h0, 32'h0);
    idle(2);
    cmp_irq(1'b0);
    bus(1'b1, ADDR_MASK, 32'h8, 32'h0);
    bus(1'b0, ADDR_EVENT, 32'h8, 32'hF);
    idle(3);
    cmp_irq(1'b0);
    bus(1'b0, ADDR_STATUS, 32'(st_m), 32'h3FF);
    bus(1'b0, ADDR_CTRL, 32'h7, 32'h7);
    bus(1'b0, ADDR_ACCUMULATOR_A_LO, acc_m[0][31:0], 32'hFFFFFFFF);
    bus(1'b0, ADDR_ACCUMULATOR_B_HI, 32'(acc_m[1][39:32]), 32'hFFFFFFFF);
    bus(1'b0, ADDR_SP, 32'(sp_m), 32'hFFFF);
    idle(1);
    for (int i = 0; i < 20 && (eq.size() + rq.size()) > 0; i++) @(posedge clk_sys_in);
    if ((eq.size() + rq.size()) > 0) err("expected results never came");
    summarize();
  end
endmodule : tb_top
